// ### logic/mode_supervisor_consts.vh
// constants for the mode and supervision logic: register map, fields, reset values, times
// assumes the including file runs on a 50 MHz clock
`ifndef MODE_SUPERVISOR_CONSTS_VH
`define MODE_SUPERVISOR_CONSTS_VH
// clock rate and times in their own units
`define CLK_MHZ          50
`define NREQ_TIME_MS     350
`define INT_PULSE_US     10
`define RESET_TIME_MS    1
`define WD_BASE_MS       10
`define CYCLIC_PERIOD_MS 20
`define CYCLIC_ON_US     100
`define FORCED_WAKE_MS   1000
// serial register addresses (3 bits)
`define ADDR_MODE        3'h0
`define ADDR_RESET_CTRL  3'h1
`define ADDR_WATCHDOG    3'h2
`define ADDR_IRQ_ENABLE  3'h3
`define ADDR_IRQ_FLAGS   3'h4
`define ADDR_IO_STATUS   3'h5
`define ADDR_LEVELS      3'h6
// mode commands in the mode control register
`define CMD_NORMAL       3'h0
`define CMD_STANDBY      3'h1
`define CMD_STOP         3'h2
`define CMD_SLEEP        3'h3
// interrupt flag and enable bit positions
`define IRQ_BAT_BIT      0
`define IRQ_HOT_BIT      1
`define IRQ_SW_BIT       2
// io status bit positions
`define IO_BATTERY_FAILURE_BIT_BIT   0
`define IO_BATLOW_BIT    1
`define IO_SECONDARY_SUPPLY_LOW_BIT_BIT     2
`define IO_HSOT_BIT      3
// io control (write) bit positions
`define IO_HS_ON_BIT     0
`define IO_CYCLIC_BIT    1
// reset values
`define IRQ_EN_RST       4'h0
`define WD_SEL_RST       2'h3
`define IO_CTRL_RST      2'h0
`define WD_STOP_RST      1'b0
`endif

// ### logic/mode_supervisor.v
// mode sequencer, supervision flags and serial register port of the basis chip
// assumes analog comparators, wake receiver and serial pins arrive asynchronously on mclk
`default_nettype none
`include "mode_supervisor_consts.vh"

module mode_supervisor #(
    parameter NREQ_CYCLES   = `NREQ_TIME_MS * 1000 * `CLK_MHZ,
    parameter RESET_CYCLES  = `RESET_TIME_MS * 1000 * `CLK_MHZ,
    parameter WD_BASE_CYC   = `WD_BASE_MS * 1000 * `CLK_MHZ,
    parameter CYC_PERIOD    = `CYCLIC_PERIOD_MS * 1000 * `CLK_MHZ,
    parameter CYC_ON        = `CYCLIC_ON_US * `CLK_MHZ,
    parameter FORCED_CYCLES = `FORCED_WAKE_MS * 1000 * `CLK_MHZ
) (
    input  wire       mclk,
    input  wire       nrst,
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       mosi,
    output reg        miso,
    output reg        miso_oe,
    input  wire [3:0] level_inputs,
    input  wire       main_reg_undervoltage,
    input  wire       battery_below_fail,
    input  wire       battery_below_warn,
    input  wire       main_reg_above_warn_temp,
    input  wire       main_reg_above_shutdown_temp,
    input  wire       secondary_supply_sense_low,
    input  wire       switch_overtemp_shutdown,
    input  wire       bus_wake,
    input  wire       main_reg_overcurrent,
    output reg        rst_n,
    output reg        int_n,
    output reg        watchdog_flag_output_n,
    output reg        main_regulator_enable,
    output reg        main_regulator_low_power,
    output reg        secondary_regulator_drive,
    output reg        high_side_output,
    output reg        precise_osc_select,
    output reg  [2:0] mode_state
);
    localparam TW = 32;
    localparam [TW-1:0] PULSE_CYC = `INT_PULSE_US * `CLK_MHZ;
    localparam [2:0] ST_RESET   = 3'h0;
    localparam [2:0] ST_NREQ    = 3'h1;
    localparam [2:0] ST_NORMAL  = 3'h2;
    localparam [2:0] ST_STANDBY = 3'h3;
    localparam [2:0] ST_STOP    = 3'h4;
    localparam [2:0] ST_SLEEP   = 3'h5;
    localparam NS = 16;
    localparam [NS-1:0] SYNC_RST = 16'h8000;   // chip select idles high, so its flops start high: no false edge

    // two-flop synchronisers for every asynchronous input
    wire [NS-1:0] async_in = {cs_n, sclk, mosi, level_inputs, main_reg_undervoltage, battery_below_fail,
                              battery_below_warn, main_reg_above_warn_temp, main_reg_above_shutdown_temp,
                              secondary_supply_sense_low, switch_overtemp_shutdown, bus_wake,
                              main_reg_overcurrent};
    wire [NS-1:0] sync_in;
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
            reg meta_reg;
            reg sync_reg;
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    meta_reg <= SYNC_RST[gi];
                    sync_reg <= SYNC_RST[gi];
                end else begin
                    meta_reg <= async_in[gi];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_in[gi] = sync_reg;
        end
    endgenerate
    wire       cs_s    = sync_in[15];
    wire       sclk_s  = sync_in[14];
    wire       mosi_s  = sync_in[13];
    wire [3:0] lvl_s   = sync_in[12:9];
    wire       uv_s    = sync_in[8];
    wire       bfail_s = sync_in[7];
    wire       bwarn_s = sync_in[6];
    wire       hot_s   = sync_in[5];
    wire       shut_s  = sync_in[4];
    wire       secondary_supply_low_bit_s = sync_in[3];
    wire       hsot_s  = sync_in[2];
    wire       bus_s   = sync_in[1];
    wire       ovc_s   = sync_in[0];

    reg           cs_d_reg;
    reg           sclk_d_reg;
    reg     [3:0] bit_cnt_reg;
    reg     [7:0] rx_reg;
    reg     [3:0] tx_reg;
    reg     [2:0] state_reg;
    reg     [2:0] state_next;
    reg  [TW-1:0] tmr_reg;
    reg  [TW-1:0] wd_cnt_reg;
    reg  [TW-1:0] pulse_cnt_reg;
    reg  [TW-1:0] cyc_cnt_reg;
    reg  [TW-1:0] forced_cnt_reg;
    reg           from_sleep_reg;
    reg     [3:0] irq_en_reg;
    reg     [2:0] irq_flag_reg;
    reg     [1:0] wd_sel_reg;
    reg     [1:0] io_ctrl_reg;
    reg           wd_stop_reg;
    reg           battery_failure_bit_reg;
    reg     [3:0] level_ref_reg;

    // serial edges seen by the mclk domain; chip select gates everything
    wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_s;
    wire cs_rise   = cs_s & ~cs_d_reg;
    wire cs_fall   = ~cs_s & cs_d_reg;
    wire frame_ok  = cs_rise & (bit_cnt_reg == 4'h8);
    wire wr_stb    = frame_ok & rx_reg[7];
    wire [2:0] wr_addr = rx_reg[6:4];
    wire [3:0] wr_data = rx_reg[3:0];
    wire addr_ready = sclk_fall & (bit_cnt_reg == 4'h3);
    wire [2:0] rd_addr = {rx_reg[1:0], mosi_s};
    wire wd_write = wr_stb & (wr_addr == `ADDR_WATCHDOG);
    wire mode_write = wr_stb & (wr_addr == `ADDR_MODE);

    // watchdog period doubles per select step
    wire [TW-1:0] wd_limit = WD_BASE_CYC << wd_sel_reg;
    wire active_mode = (state_reg == ST_NORMAL) | (state_reg == ST_STANDBY);
    wire wd_running  = active_mode | ((state_reg == ST_STOP) & wd_stop_reg);
    wire wd_timeout  = wd_running & (wd_cnt_reg >= wd_limit - 1);

    // cyclic sense window and level wake detection
    wire low_power_mode = (state_reg == ST_STOP) | (state_reg == ST_SLEEP);
    wire cyc_window = low_power_mode & io_ctrl_reg[`IO_CYCLIC_BIT] & (cyc_cnt_reg < CYC_ON);
    wire lvl_check  = io_ctrl_reg[`IO_CYCLIC_BIT] ? (cyc_cnt_reg == CYC_ON - 1) : 1'b1;
    wire lvl_wake   = low_power_mode & lvl_check & (lvl_s != level_ref_reg);
    wire forced_wake = low_power_mode & (forced_cnt_reg >= FORCED_CYCLES - 1);
    wire any_wake   = lvl_wake | forced_wake | bus_s;
    wire stop_wake  = (state_reg == ST_STOP) & (any_wake | ovc_s | cs_rise);

    // read data multiplexer
    reg [3:0] rd_data;
    always @* begin
        case (rd_addr)
            `ADDR_MODE:       rd_data = {hot_s, state_reg};
            `ADDR_RESET_CTRL: rd_data = {3'h0, wd_stop_reg};
            `ADDR_WATCHDOG:   rd_data = {~watchdog_flag_output_n, 1'b0, wd_sel_reg};
            `ADDR_IRQ_ENABLE: rd_data = irq_en_reg;
            `ADDR_IRQ_FLAGS:  rd_data = {1'b0, irq_flag_reg};
            `ADDR_IO_STATUS:  rd_data = {hsot_s, secondary_supply_low_bit_s, bwarn_s, battery_failure_bit_reg};
            `ADDR_LEVELS:     rd_data = lvl_s;
            default:          rd_data = 4'h0;
        endcase
    end

    // one exclusive mode machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (!uv_s && tmr_reg >= RESET_CYCLES - 1) begin
                    state_next = ST_NREQ;
                end
            end
            ST_NREQ: begin
                if (uv_s) begin
                    state_next = ST_RESET;
                end else if (wd_write) begin
                    state_next = ST_NORMAL;
                end else if (tmr_reg >= NREQ_CYCLES - 1) begin
                    state_next = from_sleep_reg ? ST_SLEEP : ST_RESET;
                end
            end
            ST_NORMAL, ST_STANDBY: begin
                if (uv_s || wd_timeout) begin
                    state_next = ST_RESET;
                end else if (mode_write) begin
                    case (wr_data[2:0])
                        `CMD_NORMAL:  state_next = ST_NORMAL;
                        `CMD_STANDBY: state_next = ST_STANDBY;
                        `CMD_STOP:    state_next = ST_STOP;
                        `CMD_SLEEP:   state_next = ST_SLEEP;
                        default:      state_next = state_reg;
                    endcase
                end
            end
            ST_STOP: begin
                if (uv_s || wd_timeout) begin
                    state_next = ST_RESET;
                end else if (stop_wake) begin
                    state_next = ST_NREQ;
                end
            end
            ST_SLEEP: begin
                if (any_wake) begin
                    state_next = ST_RESET;
                end
            end
            default: state_next = ST_RESET;
        endcase
    end

    // serial shift logic: sample on falling edge, shift out on rising edge
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cs_d_reg    <= 1'b1;
            sclk_d_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            rx_reg      <= 8'h00;
            tx_reg      <= 4'h0;
            miso        <= 1'b0;
            miso_oe     <= 1'b0;
        end else begin
            cs_d_reg   <= cs_s;
            sclk_d_reg <= sclk_s;
            miso_oe    <= ~cs_s;
            if (cs_fall) begin
                bit_cnt_reg <= 4'h0;
                tx_reg      <= 4'h0;
                miso        <= 1'b0;
            end else if (sclk_fall) begin
                rx_reg <= {rx_reg[6:0], mosi_s};
                if (bit_cnt_reg != 4'hF) begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                if (addr_ready) begin
                    tx_reg <= rd_data;
                end
            end else if (sclk_rise) begin
                miso   <= tx_reg[3];
                tx_reg <= {tx_reg[2:0], 1'b0};
            end
        end
    end

    // mode timers, watchdog and configuration registers
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg      <= ST_RESET;
            tmr_reg        <= {TW{1'b0}};
            wd_cnt_reg     <= {TW{1'b0}};
            pulse_cnt_reg  <= {TW{1'b0}};
            cyc_cnt_reg    <= {TW{1'b0}};
            forced_cnt_reg <= {TW{1'b0}};
            from_sleep_reg <= 1'b0;
            irq_en_reg     <= `IRQ_EN_RST;
            wd_sel_reg     <= `WD_SEL_RST;
            io_ctrl_reg    <= `IO_CTRL_RST;
            wd_stop_reg    <= `WD_STOP_RST;
            level_ref_reg  <= 4'h0;
            watchdog_flag_output_n <= 1'b1;
        end else begin
            state_reg <= state_next;
            tmr_reg <= (state_next != state_reg) ? {TW{1'b0}} : tmr_reg + 1;
            if (state_reg == ST_SLEEP && state_next == ST_RESET) begin
                from_sleep_reg <= 1'b1;
            end else if (state_next == ST_NORMAL || state_next == ST_STANDBY || state_next == ST_STOP) begin
                from_sleep_reg <= 1'b0;
            end
            // watchdog counts while running, cleared by a watchdog register write
            if (wd_write || !wd_running || wd_timeout) begin
                wd_cnt_reg <= {TW{1'b0}};
            end else begin
                wd_cnt_reg <= wd_cnt_reg + 1;
            end
            if (wd_timeout) begin
                watchdog_flag_output_n <= 1'b0;
            end else if (wd_write) begin
                watchdog_flag_output_n <= 1'b1;
            end
            // stop wake pulse on the interrupt output
            if (state_reg == ST_STOP && state_next == ST_NREQ) begin
                pulse_cnt_reg <= PULSE_CYC;
            end else if (pulse_cnt_reg != {TW{1'b0}}) begin
                pulse_cnt_reg <= pulse_cnt_reg - 1;
            end
            // low-power timers and the reference levels for wake detection
            if (!low_power_mode || state_next != state_reg) begin
                cyc_cnt_reg    <= {TW{1'b0}};
                forced_cnt_reg <= {TW{1'b0}};
                level_ref_reg  <= lvl_s;
            end else begin
                cyc_cnt_reg    <= (cyc_cnt_reg >= CYC_PERIOD - 1) ? {TW{1'b0}} : cyc_cnt_reg + 1;
                forced_cnt_reg <= forced_cnt_reg + 1;
            end
            if (wr_stb) begin
                case (wr_addr)
                    `ADDR_RESET_CTRL: wd_stop_reg <= wr_data[0];
                    `ADDR_WATCHDOG:   wd_sel_reg  <= wr_data[1:0];
                    `ADDR_IRQ_ENABLE: irq_en_reg  <= wr_data;
                    `ADDR_IO_STATUS:  io_ctrl_reg <= wr_data[1:0];
                    default:          wd_sel_reg  <= wd_sel_reg;
                endcase
            end
        end
    end

    // sticky fault flags; a new event wins over a clear in the same cycle
    wire rd_io = addr_ready & (rd_addr == `ADDR_IO_STATUS);
    wire [2:0] irq_set = {hsot_s | secondary_supply_low_bit_s, hot_s, bwarn_s & active_mode};
    wire [2:0] irq_clr = (wr_stb && wr_addr == `ADDR_IRQ_FLAGS) ? wr_data[2:0] : 3'h0;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_reg <= 3'h0;
            battery_failure_bit_reg  <= 1'b0;
        end else begin
            irq_flag_reg <= (irq_flag_reg & ~irq_clr) | irq_set;
            battery_failure_bit_reg  <= (battery_failure_bit_reg & ~rd_io) | bfail_s;
        end
    end

    // registered outputs
    wire irq_active = |(irq_flag_reg & irq_en_reg[2:0]);
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_n                     <= 1'b0;
            int_n                     <= 1'b1;
            main_regulator_enable     <= 1'b0;
            main_regulator_low_power  <= 1'b0;
            secondary_regulator_drive <= 1'b0;
            high_side_output          <= 1'b0;
            precise_osc_select        <= 1'b1;
            mode_state                <= ST_RESET;
        end else begin
            rst_n <= (state_next != ST_RESET) & ~uv_s;
            int_n <= ~(irq_active | (pulse_cnt_reg != {TW{1'b0}}));
            main_regulator_enable <= (state_next != ST_SLEEP) & ~shut_s;
            main_regulator_low_power <= (state_next == ST_STOP);
            secondary_regulator_drive <= (state_next == ST_NORMAL);
            high_side_output <= ~hsot_s & ((active_mode & io_ctrl_reg[`IO_HS_ON_BIT]) | cyc_window);
            precise_osc_select <= ~((state_next == ST_STOP) | (state_next == ST_SLEEP));
            mode_state <= state_next;
        end
    end
endmodule // mode_supervisor
`default_nettype wire

// ### testbench/mode_supervisor_asserts.sv
// checker for the mode supervisor: mode to output relations and reset timing
// assumes it is bound to the design top and sees only its ports
`default_nettype none
module mode_supervisor_asserts #(
    parameter RESET_CYCLES = 100
) (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       cs_n,
    input wire logic       miso_oe,
    input wire logic       main_reg_undervoltage,
    input wire logic       main_reg_above_shutdown_temp,
    input wire logic       rst_n,
    input wire logic       int_n,
    input wire logic       main_regulator_enable,
    input wire logic       main_regulator_low_power,
    input wire logic       secondary_regulator_drive,
    input wire logic       precise_osc_select,
    input wire logic [2:0] mode_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [31:0] low_cnt_reg;
    // counts cycles with the reset output held low
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_reg <= 32'h0;
        end else begin
            low_cnt_reg <= rst_n ? 32'h0 : low_cnt_reg + 32'h1;
        end
    end
    sequence stop_left_s;
        $past(mode_state) == 3'h4 && mode_state == 3'h1;
    endsequence
    sequence pulse_low_s;
        (!int_n) [*8];
    endsequence
    reset_low_a: assert property ((mode_state == 3'h0) [*2] |-> !rst_n)
        else $error("reset output high in reset mode");
    run_high_a: assert property ((mode_state != 3'h0 && !main_reg_undervoltage) [*4] |-> rst_n)
        else $error("reset output low outside reset mode");
    undervolt_rst_a: assert property (main_reg_undervoltage [*4] |-> !rst_n)
        else $error("undervoltage did not pull reset low");
    wake_pulse_a: assert property (stop_left_s |-> ##[0:3] pulse_low_s)
        else $error("no interrupt pulse after stop wake");
    reset_hold_a: assert property ($rose(rst_n) |-> low_cnt_reg >= RESET_CYCLES - 2)
        else $error("reset output released too early");
    stop_power_a: assert property ((mode_state == 3'h4) [*2] |-> main_regulator_low_power && !secondary_regulator_drive)
        else $error("stop mode regulator states wrong");
    standby_sec_a: assert property ((mode_state == 3'h3) [*2] |-> !secondary_regulator_drive)
        else $error("secondary drive on in standby");
    coarse_osc_a: assert property ((mode_state >= 3'h4) [*2] |-> !precise_osc_select)
        else $error("precise oscillator in low power mode");
    precise_osc_a: assert property ((mode_state <= 3'h3) [*2] |-> precise_osc_select)
        else $error("coarse oscillator in active mode");
    hot_off_a: assert property (main_reg_above_shutdown_temp [*4] |-> !main_regulator_enable)
        else $error("regulator on above shutdown temperature");
    deselect_quiet_a: assert property (cs_n [*4] |-> !miso_oe)
        else $error("miso driven while deselected");
    select_drive_a: assert property ((!cs_n) [*4] |-> miso_oe)
        else $error("miso not driven while selected");
    one_mode_a: assert property (mode_state <= 3'h5)
        else $error("mode state out of range");
endmodule // mode_supervisor_asserts
`default_nettype wire

// ### testbench/host_spi_model.sv
// host controller model: 8-bit serial frames, clock idle low, msb first
// assumes the device samples mosi on the clock fall and moves miso on the rise
`default_nettype none
module host_spi_model (
    input  wire logic mclk,
    input  wire logic miso,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic mosi
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 80; // half of the 160 ns link clock period
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b1;
    end
    // one access per frame; the link clock stands low between frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h0;
        @(posedge mclk);
        #7;
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #(HALF - 10);
            if (i < 7) rx = {rx[6:0], miso}; // bit put out at the last rise
            mosi = tx[i]; // changed well after the fall so the synced sample is safe
            #10;
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
        end
        #(HALF - 10);
        rx = {rx[6:0], miso};
        #10;
        cs_n = 1'b1;
        mosi = ~mosi; // released line shows no stale value
        #(2 * HALF);
    endtask
endmodule // host_spi_model
`default_nettype wire

// ### testbench/sbc_mode_supervisor_test.sv
// bench top: mode supervisor with shortened timers, host model and checker
// assumes a 50 MHz mclk and the register map of the constants header
`default_nettype none
`include "mode_supervisor_consts.vh"
module sbc_mode_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] lv = 4'h0;
    logic [8:0] sense = 9'h0; // uv fail warn hot shut secondary_supply_low_bit swot bus oc
    logic       cs_n, sclk, mosi, miso, miso_oe, rst_n, int_n, wd_n;
    logic       reg_en, reg_lp, sec_drv, hs_out, osc_sel;
    logic [2:0] mode_state;
    int         mismatches = 0, compares = 0, cyc = 0, run = 0, last_pulse = 0, seed = 7535;
    always #10 mclk = ~mclk;
    mode_supervisor #(.NREQ_CYCLES(2000), .RESET_CYCLES(100), .WD_BASE_CYC(500), .CYC_ON(50),
        .FORCED_CYCLES(5000)) u_mode_supervisor (
        .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .level_inputs(lv), .main_reg_undervoltage(sense[0]), .battery_below_fail(sense[1]),
        .battery_below_warn(sense[2]), .main_reg_above_warn_temp(sense[3]),
        .main_reg_above_shutdown_temp(sense[4]), .secondary_supply_sense_low(sense[5]),
        .switch_overtemp_shutdown(sense[6]), .bus_wake(sense[7]), .main_reg_overcurrent(sense[8]),
        .rst_n(rst_n), .int_n(int_n), .watchdog_flag_output_n(wd_n), .main_regulator_enable(reg_en),
        .main_regulator_low_power(reg_lp), .secondary_regulator_drive(sec_drv),
        .high_side_output(hs_out), .precise_osc_select(osc_sel), .mode_state(mode_state));
    host_spi_model u_host_spi_model (.mclk(mclk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        check(what, {15'h0, exp}, {15'h0, got});
    endtask
    task automatic wr(input logic [2:0] a, input logic [3:0] v);
        logic [7:0] r;
        u_host_spi_model.xfer({1'b1, a, v}, r);
    endtask
    task automatic rd(input logic [2:0] a, output logic [3:0] v);
        logic [7:0] r;
        u_host_spi_model.xfer({1'b0, a, 4'h0}, r);
        v = r[3:0];
    endtask
    task automatic wait_mode(input logic [2:0] m, input int lim);
        for (int n = 0; n < lim && mode_state !== m; n++) @(negedge mclk);
        check("mode_state", {13'h0, m}, {13'h0, mode_state});
    endtask
    task automatic set_in(input int i, input logic v);
        @(posedge mclk);
        sense[i] <= v;
    endtask
    // enter stop, wake by chip select, level change, bus or overcurrent, back to normal
    task automatic stop_wake(input int src);
        logic [3:0] v;
        wr(`ADDR_IO_STATUS, {2'h0, (src == 1), 1'b0});
        wr(`ADDR_MODE, {1'b0, `CMD_STOP});
        wait_mode(3'h4, 50);
        chk1("low_power", 1'b1, reg_lp);
        chk1("sec_drive", 1'b0, sec_drv);
        chk1("osc_sel", 1'b0, osc_sel);
        @(negedge mclk);
        chk1("hs_cyclic", (src == 1), hs_out);
        repeat (20) @(posedge mclk);
        last_pulse = 0;
        if (src == 0) rd(`ADDR_LEVELS, v);
        else if (src == 1) lv <= ~lv;
        else set_in(src + 5, 1'b1);
        wait_mode(3'h1, 100);
        if (src > 1) set_in(src + 5, 1'b0);
        repeat (600) @(posedge mclk);
        check("int_pulse", `INT_PULSE_US * `CLK_MHZ, last_pulse[15:0]);
        wr(`ADDR_WATCHDOG, 4'h3);
        wait_mode(3'h2, 20);
    endtask
    // length of each low stretch of the interrupt output
    always @(negedge mclk) begin
        if (int_n === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_pulse <= run;
            run <= 0;
        end
    end
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        logic [3:0] v;
        logic [3:0] e;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        chk1("rst_n", 1'b0, rst_n);
        wait_mode(3'h1, 200);
        chk1("rst_n", 1'b1, rst_n);
        chk1("osc_sel", 1'b1, osc_sel);
        for (int k = 0; k < 3; k++) begin
            e = 4'($random(seed));
            @(posedge mclk);
            lv <= e;
            rd(`ADDR_LEVELS, v);
            check("levels", {12'h0, e}, {12'h0, v});
        end
        wr(`ADDR_WATCHDOG, 4'h3);
        wait_mode(3'h2, 20);
        chk1("sec_drive", 1'b1, sec_drv);
        $display("test reset and normal entry finished");
        wr(`ADDR_IRQ_ENABLE, 4'h1);
        set_in(2, 1'b1);
        repeat (10) @(negedge mclk);
        chk1("int_n", 1'b0, int_n);
        @(posedge mclk);
        sense <= 9'h06A;
        repeat (10) @(negedge mclk);
        chk1("int_n", 1'b0, int_n);
        rd(`ADDR_MODE, v);
        check("mode_reg", 16'hA, {12'h0, v});
        rd(`ADDR_IO_STATUS, v);
        check("io_status", 16'hD, {12'h0, v});
        rd(`ADDR_IRQ_FLAGS, v);
        check("irq_flags", 16'h7, {12'h0, v});
        wr(`ADDR_IRQ_FLAGS, 4'h1);
        chk1("int_n", 1'b1, int_n);
        @(posedge mclk);
        sense <= 9'h000;
        wr(`ADDR_IRQ_FLAGS, 4'hF);
        wr(`ADDR_WATCHDOG, 4'h3);
        $display("test flags finished");
        wr(`ADDR_IO_STATUS, 4'h1);
        chk1("hs_out", 1'b1, hs_out);
        wr(`ADDR_IO_STATUS, 4'h0);
        chk1("hs_out", 1'b0, hs_out);
        wr(`ADDR_MODE, {1'b0, `CMD_STANDBY});
        wait_mode(3'h3, 20);
        chk1("sec_drive", 1'b0, sec_drv);
        for (int s = 0; s < 4; s++) stop_wake(s);
        $display("test stop wake finished");
        wait_mode(3'h0, 6000);
        chk1("wd_flag", 1'b0, wd_n);
        wait_mode(3'h1, 200);
        wr(`ADDR_WATCHDOG, 4'h3);
        wait_mode(3'h2, 20);
        chk1("wd_flag", 1'b1, wd_n);
        wr(`ADDR_MODE, {1'b0, `CMD_SLEEP});
        wait_mode(3'h5, 20);
        chk1("osc_sel", 1'b0, osc_sel);
        set_in(7, 1'b1);
        wait_mode(3'h0, 100);
        set_in(7, 1'b0);
        wait_mode(3'h1, 200);
        wr(`ADDR_WATCHDOG, 4'h3);
        wait_mode(3'h2, 20);
        $display("test watchdog and sleep finished");
        set_in(4, 1'b1);
        repeat (8) @(negedge mclk);
        chk1("reg_en", 1'b0, reg_en);
        set_in(4, 1'b0);
        set_in(0, 1'b1);
        wait_mode(3'h0, 20);
        chk1("rst_n", 1'b0, rst_n);
        set_in(0, 1'b0);
        wait_mode(3'h1, 200);
        wait_mode(3'h0, 2100);
        $display("test faults finished");
        give_verdict();
    end
endmodule // sbc_mode_supervisor_test
bind mode_supervisor mode_supervisor_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_mode_supervisor_asserts (
    .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .miso_oe(miso_oe), .main_reg_undervoltage(main_reg_undervoltage),
    .main_reg_above_shutdown_temp(main_reg_above_shutdown_temp), .rst_n(rst_n), .int_n(int_n),
    .main_regulator_enable(main_regulator_enable), .main_regulator_low_power(main_regulator_low_power),
    .secondary_regulator_drive(secondary_regulator_drive), .precise_osc_select(precise_osc_select),
    .mode_state(mode_state));
`default_nettype wire
